// ==== pkg/stp_pkg.sv ====
`default_nettype none
package stp_pkg;
   // Target addresses (7-bit) and register indices
   localparam logic [6:0] STP_TARGET_ADDR = 7'h28;
   localparam logic [6:0] STP_BOOT_ERR_ADDR = 7'h4c;
   localparam logic [7:0] STP_IDX_STATUS = 8'h09;
   localparam logic [7:0] STP_IDX_CTRL = 8'h0c;
   // Reset values
   localparam logic [7:0] STP_CTRL_RESET = 8'h00;
   localparam logic [7:0] STP_STATUS_RESET = 8'h00;
   localparam logic [7:0] STP_IDX_RESET = 8'h00;
   // Operation state command that reinitialises the registers
   localparam logic [2:0] STP_SS_RESET_SLEEP = 3'h4;
   // Bits per byte on the link; the ninth clock is the acknowledge slot
   localparam logic [3:0] STP_LAST_BIT = 4'h7;
   localparam logic [3:0] STP_ACK_SLOT = 4'h8;
   // Link timing
   localparam int STP_SCL_MAX_KHZ = 400;
   localparam int STP_REF_PERIOD_NS = 40;
   localparam int STP_SCL_MIN_PERIOD_NS = 1000000 / STP_SCL_MAX_KHZ;
   localparam int STP_SCL_MIN_CYCLES =
      (STP_SCL_MIN_PERIOD_NS + STP_REF_PERIOD_NS - 1) / STP_REF_PERIOD_NS;

   typedef struct packed {
      logic reserved;
      logic [2:0] standby_time;
      logic en_heater;
      logic [2:0] set_state;
   } stp_ctrl_s;

   typedef struct packed {
      logic reserved;
      logic err_heat;
      logic boot_load_error_flag;
      logic err_info;
      logic rdy_data;
      logic [2:0] state;
   } stp_status_s;

   typedef struct packed {
      logic err_heat;
      logic err_info;
      logic [2:0] state;
   } stp_core_status_s;

   typedef struct packed {
      logic [15:0] humidity;
      logic [15:0] temperature;
   } stp_frame_s;

   typedef struct packed {
      stp_status_s status;
      stp_ctrl_s ctrl;
      stp_frame_s frame;
   } stp_hold_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_INDEX,
      ST_WDATA,
      ST_SEND,
      ST_SKIP
   } stp_link_e;
endpackage : stp_pkg
`default_nettype wire

// ==== logic/stp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module stp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_out;

   // A bit moves only once the second and third stages agree
   always_comb begin
      next_out = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & sync_out);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         sync_out <= next_out;
      end
   end
endmodule : stp_sync
`default_nettype wire

// ==== logic/stp_target_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module stp_target_port (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic SCL,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire stp_pkg::stp_frame_s FRAME,
   input wire logic CONV_DONE,
   input wire logic BOOT_LOAD_FAIL,
   input wire stp_pkg::stp_core_status_s CORE_STATUS,
   input wire logic TRANSITION_BUSY,
   output stp_pkg::stp_ctrl_s CTRL,
   output stp_pkg::stp_ctrl_s CTRL_CMD,
   output logic CTRL_WRITE,
   output logic BOOT_LOAD_ERROR
);
   import stp_pkg::*;

   // Sync jitter and the counter's offset take a few cycles off the spacing
   localparam int WR_GAP_MIN = (9 * STP_SCL_MIN_PERIOD_NS) / STP_REF_PERIOD_NS - 3;

   // Start detector, clocked by the data line itself
   logic start_tgl;
   logic next_start_tgl;

   // Link domain state
   stp_link_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [7:0] shift, next_shift;
   logic ack, next_ack;
   logic [7:0] idx, next_idx;
   logic idx_fresh, next_fresh;
   logic [7:0] wdata, next_wdata;
   logic wr_tgl, next_wr_tgl;
   logic frz, next_frz;
   logic rd_frame, next_rd_frame;
   logic [31:0] txbuf, next_txbuf;
   logic start_seen, next_start_seen;
   logic next_oe;
   logic new_frame;
   logic [7:0] rx_byte;
   logic busy_s;
   logic boot_s;
   logic [6:0] act_addr;

   // Reference domain state
   logic frz_s, rdf_s, wr_s;
   logic frz_q, next_frz_q;
   logic wr_q, next_wr_q;
   stp_ctrl_s next_ctrl, next_cmd;
   logic next_write;
   logic rdy, next_rdy;
   logic next_boot;
   stp_hold_s hold, next_hold;
   stp_status_s status;
   logic wr_edge, rs_write, frame_rd_start;
   logic [15:0] gap_cnt, next_gap;

   function automatic logic [7:0] reg_read(input logic [7:0] index, input stp_hold_s h);
      logic [7:0] value;
      value = 8'h00;
      if (index == STP_IDX_STATUS) begin
         value = h.status;
      end else if (index == STP_IDX_CTRL) begin
         value = h.ctrl;
      end
      return value;
   endfunction : reg_read

   assign SDA_O = 1'b0;

   // A start is a falling data line while the clock is high
   always_comb begin
      next_start_tgl = SCL ? ~start_tgl : start_tgl;
   end

   always_ff @(negedge SDA_I or negedge RST_N) begin
      if (!RST_N) begin
         start_tgl <= 1'b0;
      end else begin
         start_tgl <= next_start_tgl;
      end
   end

   stp_sync #(.WIDTH(2)) u_link_sync (
      .clk(SCL),
      .rst_n(RST_N),
      .async_in({TRANSITION_BUSY, BOOT_LOAD_ERROR}),
      .sync_out({busy_s, boot_s})
   );

   assign act_addr = boot_s ? STP_BOOT_ERR_ADDR : STP_TARGET_ADDR;
   assign new_frame = start_tgl ^ start_seen;
   assign rx_byte = {shift[6:0], SDA_I};

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shift = shift;
      next_ack = ack;
      next_idx = idx;
      next_fresh = idx_fresh;
      next_wdata = wdata;
      next_wr_tgl = wr_tgl;
      next_frz = frz;
      next_rd_frame = rd_frame;
      next_txbuf = txbuf;
      next_start_seen = start_tgl;
      if (new_frame) begin
         // Repeated start or fresh start: this rise carries the first address bit
         next_state = ST_ADDR;
         next_cnt = 4'h1;
         next_shift = rx_byte;
         next_ack = 1'b0;
         next_frz = 1'b0;
      end else if (state != ST_IDLE && state != ST_SKIP) begin
         if (cnt != STP_ACK_SLOT) begin
            next_cnt = cnt + 4'h1;
            if (state == ST_SEND) begin
               next_txbuf = {txbuf[30:0], 1'b0};
            end else begin
               next_shift = rx_byte;
               if (cnt == STP_LAST_BIT) begin
                  unique case (state)
                     ST_ADDR: begin
                        next_ack = (rx_byte[7:1] == act_addr) && !busy_s;
                        if (next_ack && rx_byte[0]) begin
                           next_frz = 1'b1;
                           next_rd_frame = ~idx_fresh;
                        end
                     end
                     ST_INDEX: begin
                        next_ack = 1'b1;
                        next_idx = rx_byte;
                        next_fresh = 1'b1;
                     end
                     ST_WDATA: begin
                        next_ack = 1'b1;
                        next_fresh = 1'b0;
                        next_wdata = rx_byte;
                        // Other indices are acknowledged but change nothing
                        if (idx == STP_IDX_CTRL) begin
                           next_wr_tgl = ~wr_tgl;
                        end
                     end
                     ST_SEND, ST_IDLE, ST_SKIP: begin
                     end
                  endcase
               end
            end
         end else begin
            next_cnt = 4'h0;
            next_ack = 1'b0;
            unique case (state)
               ST_ADDR: begin
                  if (!ack) begin
                     next_state = ST_SKIP;
                  end else if (shift[0]) begin
                     next_state = ST_SEND;
                     next_fresh = 1'b0;
                     // Frame in humidity-then-temperature order; a register read sends one byte
                     next_txbuf = rd_frame ? hold.frame : {reg_read(idx, hold), 24'h000000};
                  end else begin
                     next_state = ST_INDEX;
                  end
               end
               ST_INDEX: begin
                  next_state = ST_WDATA;
               end
               ST_WDATA: begin
                  next_state = ST_WDATA;
               end
               ST_SEND: begin
                  // Host acknowledge keeps bytes coming; past the frame, zeros follow
                  if (SDA_I) begin
                     next_state = ST_SKIP;
                     next_frz = 1'b0;
                  end
               end
               ST_IDLE, ST_SKIP: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge SCL or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         shift <= 8'h00;
         ack <= 1'b0;
         idx <= STP_IDX_RESET;
         idx_fresh <= 1'b0;
         wdata <= STP_CTRL_RESET;
         wr_tgl <= 1'b0;
         frz <= 1'b0;
         rd_frame <= 1'b0;
         txbuf <= 32'h00000000;
         start_seen <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         shift <= next_shift;
         ack <= next_ack;
         idx <= next_idx;
         idx_fresh <= next_fresh;
         wdata <= next_wdata;
         wr_tgl <= next_wr_tgl;
         frz <= next_frz;
         rd_frame <= next_rd_frame;
         txbuf <= next_txbuf;
         start_seen <= next_start_seen;
      end
   end

   // Data line changes only while the clock is low
   always_comb begin
      next_oe = 1'b0;
      if (state == ST_SEND && cnt != STP_ACK_SLOT) begin
         next_oe = ~txbuf[31];
      end else if (cnt == STP_ACK_SLOT && ack) begin
         next_oe = 1'b1;
      end
   end

   always_ff @(negedge SCL or negedge RST_N) begin
      if (!RST_N) begin
         SDA_OE <= 1'b0;
      end else begin
         SDA_OE <= next_oe;
      end
   end

   stp_sync #(.WIDTH(3)) u_ref_sync (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .async_in({frz, rd_frame, wr_tgl}),
      .sync_out({frz_s, rdf_s, wr_s})
   );

   assign wr_edge = wr_s ^ wr_q;
   assign rs_write = wr_edge && (wdata[2:0] == STP_SS_RESET_SLEEP);
   assign frame_rd_start = frz_s && !frz_q && rdf_s;
   assign status = {1'b0, CORE_STATUS.err_heat, BOOT_LOAD_ERROR, CORE_STATUS.err_info, rdy,
                    CORE_STATUS.state};

   always_comb begin
      next_frz_q = frz_s;
      next_wr_q = wr_s;
      // Written byte is stable for a whole byte time after the toggle lands
      next_ctrl = CTRL;
      next_cmd = CTRL_CMD;
      if (wr_edge) begin
         next_cmd = stp_ctrl_s'(wdata);
         next_ctrl = rs_write ? stp_ctrl_s'(STP_CTRL_RESET) : stp_ctrl_s'(wdata);
      end
      next_write = wr_edge;
      // Setting wins over a clear in the same cycle
      next_rdy = CONV_DONE | (rdy & ~(frame_rd_start | rs_write));
      next_boot = BOOT_LOAD_FAIL | (BOOT_LOAD_ERROR & ~rs_write);
      // Snapshot frozen while a read is open; at 400 kHz it settles well before use
      next_hold = frz_s ? hold : {status, CTRL, FRAME};
      next_gap = (gap_cnt == 16'hffff) ? gap_cnt : gap_cnt + 16'h0001;
      if (wr_edge) begin
         next_gap = 16'h0000;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         frz_q <= 1'b0;
         wr_q <= 1'b0;
         CTRL <= STP_CTRL_RESET;
         CTRL_CMD <= STP_CTRL_RESET;
         CTRL_WRITE <= 1'b0;
         rdy <= 1'b0;
         BOOT_LOAD_ERROR <= 1'b0;
         hold <= {STP_STATUS_RESET, STP_CTRL_RESET, 32'h00000000};
         gap_cnt <= 16'hffff;
      end else begin
         frz_q <= next_frz_q;
         wr_q <= next_wr_q;
         CTRL <= next_ctrl;
         CTRL_CMD <= next_cmd;
         CTRL_WRITE <= next_write;
         rdy <= next_rdy;
         BOOT_LOAD_ERROR <= next_boot;
         hold <= next_hold;
         gap_cnt <= next_gap;
      end
   end

   addr_ack_drive_a: assert property (@(posedge SCL) disable iff (!RST_N)
      (state == ST_ADDR && cnt == STP_ACK_SLOT && ack) |-> SDA_OE)
      else $error("matched address not acknowledged on the data line");

   rw_steer_a: assert property (@(posedge SCL) disable iff (!RST_N)
      (!new_frame && state == ST_ADDR && cnt == STP_ACK_SLOT && ack && shift[0])
      |=> (state == ST_SEND && cnt == 4'h0))
      else $error("read direction bit did not start sending");

   index_ack_a: assert property (@(posedge SCL) disable iff (!RST_N)
      (state == ST_INDEX && cnt == STP_ACK_SLOT) |-> SDA_OE)
      else $error("register index not acknowledged");

   busy_nack_a: assert property (@(posedge SCL) disable iff (!RST_N)
      (state == ST_ADDR && cnt == STP_ACK_SLOT && $past(busy_s)) |-> !SDA_OE)
      else $error("address acknowledged while busy");

   msb_first_a: assert property (@(posedge SCL) disable iff (!RST_N)
      (state == ST_SEND && cnt != STP_ACK_SLOT) |-> (SDA_OE == !txbuf[31]))
      else $error("sent bit differs from the top of the frame");

   frame_order_a: assert property (@(posedge SCL) disable iff (!RST_N)
      (!new_frame && state == ST_ADDR && cnt == STP_ACK_SLOT && ack && shift[0] && rd_frame)
      |=> (txbuf[31:16] == $past(hold.frame.humidity)
           && txbuf[15:0] == $past(hold.frame.temperature)))
      else $error("frame not loaded humidity first");

   reg_read_a: assert property (@(posedge SCL) disable iff (!RST_N)
      (!new_frame && state == ST_ADDR && cnt == STP_ACK_SLOT && ack && shift[0] && !rd_frame
       && idx == STP_IDX_STATUS) |=> (txbuf[31:24] == $past(hold.status)))
      else $error("status read returned the wrong byte");

   restart_a: assert property (@(posedge SCL) disable iff (!RST_N)
      new_frame |=> (state == ST_ADDR && cnt == 4'h1 && !ack))
      else $error("start did not restart address reception");

   rdy_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (frame_rd_start && rdy && !CONV_DONE) |=> !rdy)
      else $error("result-ready flag not cleared by frame read");

   boot_err_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (BOOT_LOAD_FAIL |=> BOOT_LOAD_ERROR) and ((rs_write && !BOOT_LOAD_FAIL) |=> !BOOT_LOAD_ERROR))
      else $error("boot load error flag wrong");

   ctrl_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      wr_edge |=> (CTRL_WRITE && CTRL_CMD == $past(wdata)) ##1 !CTRL_WRITE)
      else $error("control write not forwarded once");

   scl_rate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      wr_edge |-> (gap_cnt >= 16'(WR_GAP_MIN)))
      else $error("control writes closer than the fastest link allows");

   hold_frozen_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (frz_s && $past(frz_s)) |-> $stable(hold))
      else $error("read snapshot changed during a read");
endmodule : stp_target_port
`default_nettype wire

// ==== tb/stp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module stp_host_model #(
   parameter int HALF_NS = 1250,
   parameter int RETRY_NS = 3000000
) (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   localparam int Q_NS = HALF_NS / 4;
   // Clock stands high between frames; half period keeps it at 400 kHz or below
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Data moves an eighth of a period after the fall, so it never fakes a start or stop
   task automatic bit_io(input logic b, output logic r);
      #(Q_NS);
      sda_pull = ~b;
      #(HALF_NS - Q_NS);
      scl = 1'b1;
      #(HALF_NS);
      r = sda;
      scl = 1'b0;
   endtask : bit_io
   // Also serves as repeated start
   task automatic start;
      #(Q_NS);
      sda_pull = 1'b0;
      #(HALF_NS - Q_NS);
      scl = 1'b1;
      #(HALF_NS);
      sda_pull = 1'b1;
      #(HALF_NS);
      scl = 1'b0;
   endtask : start
   task automatic stop;
      #(Q_NS);
      sda_pull = 1'b1;
      #(HALF_NS - Q_NS);
      scl = 1'b1;
      #(HALF_NS);
      sda_pull = 1'b0;
      #(HALF_NS);
   endtask : stop
   // MSB first; line released in the ninth slot for the answer
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wbyte
   // Acknowledge every byte but the last, which is refused
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(last, r);
   endtask : rbyte
   task automatic back_off;
      #(RETRY_NS);
   endtask : back_off
endmodule : stp_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import stp_pkg::*;
   logic ref_clk, rst_n, scl, sda_pull, sda, sda_o, sda_oe;
   logic conv_done, boot_fail, busy, ctrl_write, boot_err;
   stp_frame_s frame;
   stp_core_status_s core_status;
   stp_ctrl_s ctrl, ctrl_cmd;
   int miscompares, n_compared, n_wr;
   // Pull-up on the wire; either party may pull it low
   assign sda = ~((sda_oe & ~sda_o) | sda_pull);
   stp_target_port i_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .SCL(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .FRAME(frame), .CONV_DONE(conv_done),
      .BOOT_LOAD_FAIL(boot_fail), .CORE_STATUS(core_status), .TRANSITION_BUSY(busy),
      .CTRL(ctrl), .CTRL_CMD(ctrl_cmd), .CTRL_WRITE(ctrl_write), .BOOT_LOAD_ERROR(boot_err));
   // Full retry wait after a refused access
   stp_host_model #(.HALF_NS(1250), .RETRY_NS(3000000)) i_host (.scl(scl),
      .sda_pull(sda_pull), .sda(sda));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (ctrl_write === 1'b1) n_wr <= n_wr + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("compared=%0d mismatches=%0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   task automatic pulse(input int which);
      @(negedge ref_clk);
      if (which == 0) begin
         conv_done = 1'b1;
      end else begin
         boot_fail = 1'b1;
      end
      @(negedge ref_clk);
      conv_done = 1'b0;
      boot_fail = 1'b0;
   endtask : pulse
   task automatic t_write(input logic [7:0] wa, input logic [7:0] d, input logic [7:0] exp);
      logic a;
      int w0;
      w0 = n_wr;
      i_host.start();
      i_host.wbyte(wa, a);
      chk(a, 1);
      i_host.wbyte(STP_IDX_CTRL, a);
      chk(a, 1);
      i_host.wbyte(d, a);
      chk(a, 1);
      i_host.stop();
      chk(n_wr - w0, 1);
      chk(ctrl_cmd, d);
      chk(ctrl, exp);
   endtask : t_write
   task automatic t_reg_read(input logic [7:0] idx, input logic via_stop,
         input logic [7:0] exp);
      logic a;
      logic [7:0] b;
      i_host.start();
      i_host.wbyte(8'h50, a);
      chk(a, 1);
      i_host.wbyte(idx, a);
      chk(a, 1);
      if (via_stop) i_host.stop();
      i_host.start();
      i_host.wbyte(8'h51, a);
      chk(a, 1);
      i_host.rbyte(1'b1, b);
      i_host.stop();
      chk(b, exp);
   endtask : t_reg_read
   task automatic t_frame(input logic [31:0] exp);
      logic a;
      logic [7:0] b;
      logic [31:0] got;
      got = '0;
      i_host.start();
      i_host.wbyte(8'h51, a);
      chk(a, 1);
      for (int k = 0; k < 4; k++) begin
         i_host.rbyte(k == 3, b);
         got = {got[23:0], b};
      end
      i_host.stop();
      chk(got, exp);
   endtask : t_frame
   task automatic t_refused;
      logic a;
      @(negedge ref_clk);
      busy = 1'b1;
      i_host.start();
      i_host.wbyte(8'h50, a);
      chk(a, 0);
      i_host.stop();
      @(negedge ref_clk);
      busy = 1'b0;
      i_host.back_off();
   endtask : t_refused
   task automatic t_boot;
      logic a;
      pulse(1);
      chk(boot_err, 1);
      i_host.start();
      i_host.wbyte(8'h50, a);
      chk(a, 0);
      i_host.stop();
      // Reset and sleep at the fallback address clears the flag and the control register
      t_write(8'h98, 8'h04, 8'h00);
      chk(boot_err, 0);
   endtask : t_boot
   initial begin
      rst_n = 1'b0;
      conv_done = 1'b0;
      boot_fail = 1'b0;
      busy = 1'b0;
      frame = 32'hc7ae_84d3;
      core_status = 5'b1_0_001;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (10) @(negedge ref_clk);
      chk(ctrl, STP_CTRL_RESET);
      chk(boot_err, 0);
      chk(sda_oe, 0);
      t_write(8'h50, 8'h21, 8'h21);
      t_reg_read(STP_IDX_CTRL, 1'b0, 8'h21);
      pulse(0);
      t_reg_read(STP_IDX_STATUS, 1'b1, 8'h49);
      t_frame(32'hc7ae_84d3);
      t_reg_read(STP_IDX_STATUS, 1'b0, 8'h41);
      t_refused();
      t_reg_read(STP_IDX_STATUS, 1'b0, 8'h41);
      t_boot();
      t_reg_read(STP_IDX_CTRL, 1'b0, 8'h00);
      results();
   end
   initial begin
      // Clean run takes about 3.85 ms, most of it the retry wait
      #(3950000);
      miscompares++;
      results();
   end
endmodule : tb_top
`default_nettype wire
